// ===== verilog/psar_consts.vh
// Constants for the phase-step argument register bank.
// Assumes a 32-bit AXI4-Lite bus; each register index maps to one word.
`ifndef PSAR_CONSTS_VH
`define PSAR_CONSTS_VH

// Register indices; byte address is four times the index
`define PSAR_IDX_CTRL 12'h501
`define PSAR_IDX_STEP 12'h502
`define PSAR_IDX_LIMIT 12'h506
`define PSAR_IDX_MASK_LO 12'h510
`define PSAR_IDX_MASK_HI 12'h511
`define PSAR_ADDR_W 16

// Command field position and codes
`define PSAR_CMD_LSB 0
`define PSAR_CMD_MSB 1
`define PSAR_CMD_IDLE 2'h0
`define PSAR_CMD_RESET 2'h1
`define PSAR_CMD_READ 2'h2
`define PSAR_CMD_WRITE 2'h3

// Reset values
`define PSAR_STEP_RST 32'h00000000
`define PSAR_LIMIT_RST 8'h00
`define PSAR_MASK_RST 8'h00

// Writable bits of the mask registers; the rest are reserved
`define PSAR_MASK_LO_USED 8'hF3
`define PSAR_MASK_HI_USED 8'h3F

// Divider count across all synthesizers
`define PSAR_NUM_DIV 12

// Phase per step unit, in picoseconds
`define PSAR_STEP_PS 1250

// Bus responses
`define PSAR_RESP_OKAY 2'h0
`define PSAR_RESP_DECERR 2'h3

`endif

// ===== verilog/psar_axil_slave.v
// AXI4-Lite slave front end: turns bus transfers into one-cycle requests.
// Assumes the register file answers each request combinationally.
`timescale 1ns/1ps
`default_nettype none
`include "psar_consts.vh"
module psar_axil_slave (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Write address and data channels
    input wire [`PSAR_ADDR_W-1:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    // Write response channel
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // Read channels
    input wire [`PSAR_ADDR_W-1:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // Register file side
    output wire wr_req,
    output reg [`PSAR_ADDR_W-1:0] wr_addr,
    output reg [31:0] wr_data,
    output reg [3:0] wr_strb,
    input wire wr_err,
    output wire rd_req,
    output reg [`PSAR_ADDR_W-1:0] rd_addr,
    input wire [31:0] rd_data,
    input wire rd_err
);
    reg aw_have_q; // Write address held
    reg w_have_q; // Write data held
    reg ar_have_q; // Read address held
    reg aw_have_d;
    reg w_have_d;
    reg ar_have_d;
    reg bvalid_d;
    reg rvalid_d;

    // A write fires once both halves are in and the last answer is gone
    assign wr_req = aw_have_q & w_have_q & ~bvalid;
    assign rd_req = ar_have_q & ~rvalid;

    // Next state; ready drops while a half is held so one write at a time
    always @*
    begin
        aw_have_d = wr_req ? 1'b0 : (aw_have_q | (awvalid & awready));
        w_have_d = wr_req ? 1'b0 : (w_have_q | (wvalid & wready));
        bvalid_d = wr_req ? 1'b1 : (bvalid & ~bready);
        ar_have_d = rd_req ? 1'b0 : (ar_have_q | (arvalid & arready));
        rvalid_d = rd_req ? 1'b1 : (rvalid & ~rready);
    end

    // Channel state and captured payloads
    always @(posedge clk)
    begin
        if (srst)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            ar_have_q <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            arready <= 1'b0;
            bvalid <= 1'b0;
            rvalid <= 1'b0;
            bresp <= `PSAR_RESP_OKAY;
            rresp <= `PSAR_RESP_OKAY;
            rdata <= 32'h00000000;
            wr_addr <= {`PSAR_ADDR_W{1'b0}};
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
            rd_addr <= {`PSAR_ADDR_W{1'b0}};
        end
        else
        begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            ar_have_q <= ar_have_d;
            bvalid <= bvalid_d;
            rvalid <= rvalid_d;
            awready <= ~aw_have_d & ~bvalid_d;
            wready <= ~w_have_d & ~bvalid_d;
            arready <= ~ar_have_d & ~rvalid_d;
            if (awvalid && awready)
                wr_addr <= awaddr;
            if (wvalid && wready)
            begin
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (arvalid && arready)
                rd_addr <= araddr;
            // Answers are captured in the cycle of the request
            if (wr_req)
                bresp <= wr_err ? `PSAR_RESP_DECERR : `PSAR_RESP_OKAY;
            if (rd_req)
            begin
                rdata <= rd_err ? 32'h00000000 : rd_data;
                rresp <= rd_err ? `PSAR_RESP_DECERR : `PSAR_RESP_OKAY;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/psar_step_engine.v
// Per-divider phase offset accumulators for the step commands.
// Assumes go is a one-cycle pulse with stable command, step and mask.
`timescale 1ns/1ps
`default_nettype none
`include "psar_consts.vh"
module psar_step_engine (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Command from the register file
    input wire go,
    input wire [1:0] cmd,
    input wire [31:0] step,
    input wire [`PSAR_NUM_DIV-1:0] mask,
    // Results
    output reg done_q,
    output reg [31:0] result_q,
    output reg apply_q,
    output reg clear_q
);
    reg [31:0] acc_q [0:`PSAR_NUM_DIV-1]; // Running offset per divider
    reg [31:0] sel_acc; // Offset of the first selected divider
    integer i; // Loop index of the clocked process
    integer j; // Own index so the read mux shares no variable with the flops

    // Only one divider should be chosen for a read; lowest bit wins
    always @*
    begin
        sel_acc = 32'h00000000;
        for (j = `PSAR_NUM_DIV - 1; j >= 0; j = j - 1)
            if (mask[j])
                sel_acc = acc_q[j];
    end

    // Command execution, one cycle per command
    always @(posedge clk)
    begin
        if (srst)
        begin
            for (i = 0; i < `PSAR_NUM_DIV; i = i + 1)
                acc_q[i] <= 32'h00000000;
            done_q <= 1'b0;
            result_q <= 32'h00000000;
            apply_q <= 1'b0;
            clear_q <= 1'b0;
        end
        else
        begin
            done_q <= go;
            apply_q <= go && (cmd == `PSAR_CMD_WRITE);
            clear_q <= go && (cmd == `PSAR_CMD_RESET);
            if (go)
            begin
                case (cmd)
                    `PSAR_CMD_WRITE:
                    begin
                        // Steps add up; unselected dividers keep theirs
                        for (i = 0; i < `PSAR_NUM_DIV; i = i + 1)
                            if (mask[i])
                                acc_q[i] <= acc_q[i] + step;
                    end
                    `PSAR_CMD_RESET:
                    begin
                        for (i = 0; i < `PSAR_NUM_DIV; i = i + 1)
                            if (mask[i])
                                acc_q[i] <= 32'h00000000;
                    end
                    `PSAR_CMD_READ:
                        result_q <= sel_acc;
                    default:
                        result_q <= result_q;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/psar_regs.v
// Phase-step argument register bank with AXI4-Lite access and
// a small sequencer that hands each command to the step engine.
// Assumes one 200 MHz clock and a synchronous active-high reset.
//
// Summary of operation
// - Step register carries argument and read result
// - Step is signed 32-bit, LSB at lowest
// - Positive step advances, negative step delays
// - One step unit equals 1.25 ns
// - Limit register caps one move, percent period
// - Low mask bits 0,1 pick synth0 A,B
// - Low mask bits 4..7 pick synth1 A..D
// - High mask bits 0..3 pick synth2 A..D
// - High mask bits 4,5 pick synth3 A,B
// - Codes: 0 idle, 1 reset, 2 read, 3 write
// - Command field clears once the result is stored
// - Write steps accumulate on the running offset
`timescale 1ns/1ps
`default_nettype none
`include "psar_consts.vh"
module psar_regs (
    // Clock and reset
    input wire clk,
    input wire srst,
    // AXI4-Lite write address channel
    input wire [`PSAR_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data channel
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response channel
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address channel
    input wire [`PSAR_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data channel
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Phase mover side
    output wire step_apply,
    output wire step_clear,
    output wire [31:0] step_amount,
    output wire [`PSAR_NUM_DIV-1:0] step_targets,
    output wire [7:0] step_limit,
    output wire step_busy
);
    // Sequencer states
    localparam [1:0] ST_IDLE = 2'h0; // Waiting for a command
    localparam [1:0] ST_CAPT = 2'h1; // Freezing the arguments
    localparam [1:0] ST_EXEC = 2'h2; // Engine running
    localparam [1:0] ST_DONE = 2'h3; // Result being stored

    // Bus request wires
    wire wr_req; // One-cycle write request
    wire [`PSAR_ADDR_W-1:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire rd_req; // One-cycle read request
    wire [`PSAR_ADDR_W-1:0] rd_addr;
    reg [31:0] rd_data; // Read mux result
    reg rd_err; // Unmapped read
    reg wr_err; // Unmapped write

    // Software visible registers
    reg [1:0] cmd_q; // Command code field
    reg [31:0] step_q; // Step argument or result
    reg [7:0] limit_q; // Step limit in percent
    reg [7:0] mask_lo_q; // Synth 0 and 1 targets
    reg [7:0] mask_hi_q; // Synth 2 and 3 targets

    // Sequencer and captured arguments
    reg [1:0] st_q;
    reg [1:0] st_d;
    reg [1:0] run_cmd_q; // Command being executed
    reg [31:0] cap_step_q; // Frozen step argument
    reg [7:0] cap_limit_q; // Frozen limit
    reg [`PSAR_NUM_DIV-1:0] cap_mask_q; // Frozen targets
    reg go_q; // Engine start pulse
    reg busy_q; // Command pending

    // Engine results
    wire eng_done;
    wire [31:0] eng_result;

    // Index of a byte address, or all ones when not word aligned
    function [11:0] word_idx;
        input [`PSAR_ADDR_W-1:0] a;
        begin
            if (a[1:0] != 2'b00)
                word_idx = 12'hFFF;
            else
                word_idx = a[13:2];
        end
    endfunction

    // True for any index the bank answers
    function mapped;
        input [11:0] idx;
        begin
            mapped = (idx == `PSAR_IDX_CTRL) || (idx == `PSAR_IDX_STEP) ||
                (idx == `PSAR_IDX_LIMIT) || (idx == `PSAR_IDX_MASK_LO) ||
                (idx == `PSAR_IDX_MASK_HI);
        end
    endfunction

    // Byte-lane merge honouring write strobes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1)
                if (strb[k])
                    merge[k*8 +: 8] = nw[k*8 +: 8];
        end
    endfunction

    // Bus front end
    psar_axil_slave u_bus (
        .clk(clk),
        .srst(srst),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .wr_req(wr_req),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_req(rd_req),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // Accumulators live in the engine
    psar_step_engine u_eng (
        .clk(clk),
        .srst(srst),
        .go(go_q),
        .cmd(run_cmd_q),
        .step(cap_step_q),
        .mask(cap_mask_q),
        .done_q(eng_done),
        .result_q(eng_result),
        .apply_q(step_apply),
        .clear_q(step_clear)
    );

    // Outputs to the phase mover, all from flops
    assign step_amount = cap_step_q;
    assign step_targets = cap_mask_q;
    assign step_limit = cap_limit_q;
    assign step_busy = busy_q;

    // Unmapped addresses get a decode error
    always @*
    begin
        wr_err = !mapped(word_idx(wr_addr));
    end

    // Read mux; reserved bits read as zero
    always @*
    begin
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        case (word_idx(rd_addr))
            `PSAR_IDX_CTRL:
                rd_data[`PSAR_CMD_MSB:`PSAR_CMD_LSB] = cmd_q;
            `PSAR_IDX_STEP:
                rd_data = step_q;
            `PSAR_IDX_LIMIT:
                rd_data[7:0] = limit_q;
            `PSAR_IDX_MASK_LO:
                rd_data[7:0] = mask_lo_q;
            `PSAR_IDX_MASK_HI:
                rd_data[7:0] = mask_hi_q;
            default:
                rd_err = 1'b1;
        endcase
    end

    // Sequencer next state
    always @*
    begin
        case (st_q)
            ST_IDLE:
                st_d = (cmd_q != `PSAR_CMD_IDLE) ? ST_CAPT : ST_IDLE;
            ST_CAPT:
                st_d = ST_EXEC;
            ST_EXEC:
                st_d = eng_done ? ST_DONE : ST_EXEC;
            ST_DONE:
                st_d = ST_IDLE;
            default:
                st_d = ST_IDLE;
        endcase
    end

    // Register writes and command sequencing
    always @(posedge clk)
    begin
        if (srst)
        begin
            cmd_q <= `PSAR_CMD_IDLE;
            step_q <= `PSAR_STEP_RST;
            limit_q <= `PSAR_LIMIT_RST;
            mask_lo_q <= `PSAR_MASK_RST;
            mask_hi_q <= `PSAR_MASK_RST;
            st_q <= ST_IDLE;
            run_cmd_q <= `PSAR_CMD_IDLE;
            cap_step_q <= `PSAR_STEP_RST;
            cap_limit_q <= `PSAR_LIMIT_RST;
            cap_mask_q <= {`PSAR_NUM_DIV{1'b0}};
            go_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            go_q <= 1'b0;
            // Argument registers are frozen while a command runs,
            // so a stray write cannot tear a captured value
            if (wr_req && !busy_q)
            begin
                case (word_idx(wr_addr))
                    `PSAR_IDX_CTRL:
                    begin
                        // Host only sets nonzero codes; zero is ignored
                        if (wr_strb[0] &&
                            wr_data[`PSAR_CMD_MSB:`PSAR_CMD_LSB] != `PSAR_CMD_IDLE)
                        begin
                            cmd_q <= wr_data[`PSAR_CMD_MSB:`PSAR_CMD_LSB];
                            busy_q <= 1'b1;
                        end
                    end
                    `PSAR_IDX_STEP:
                        step_q <= merge(step_q, wr_data, wr_strb);
                    `PSAR_IDX_LIMIT:
                        if (wr_strb[0])
                            limit_q <= wr_data[7:0];
                    `PSAR_IDX_MASK_LO:
                        if (wr_strb[0])
                            limit_mask_lo(wr_data[7:0]);
                    `PSAR_IDX_MASK_HI:
                        if (wr_strb[0])
                            mask_hi_q <= wr_data[7:0] & `PSAR_MASK_HI_USED;
                    default:
                        busy_q <= busy_q;
                endcase
            end
            case (st_q)
                ST_CAPT:
                begin
                    // Freeze the arguments for the engine
                    run_cmd_q <= cmd_q;
                    cap_step_q <= step_q;
                    cap_limit_q <= limit_q;
                    cap_mask_q <= {mask_hi_q[5:0], mask_lo_q[7:4],
                        mask_lo_q[1:0]};
                    go_q <= 1'b1;
                end
                ST_DONE:
                begin
                    // Read result lands in the same cycle the field returns to zero
                    if (run_cmd_q == `PSAR_CMD_READ)
                        step_q <= eng_result;
                    cmd_q <= `PSAR_CMD_IDLE;
                    busy_q <= 1'b0;
                end
                default:
                    go_q <= go_q & 1'b0;
            endcase
        end
    end

    // Low mask write with reserved bits forced to zero
    task limit_mask_lo;
        input [7:0] v;
        begin
            mask_lo_q <= v & `PSAR_MASK_LO_USED;
        end
    endtask
endmodule
`default_nettype wire

// ===== tb/psar_regs_monitor.sv
// Concurrent checks on the phase-step register bank's top-level ports.
// Assumes the single clk domain and the synchronous active-high srst.
`timescale 1ns/1ps
`default_nettype none
`include "psar_consts.vh"
module psar_regs_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Phase mover side
    input wire logic step_apply,
    input wire logic step_clear,
    input wire logic [31:0] step_amount,
    input wire logic [`PSAR_NUM_DIV-1:0] step_targets,
    input wire logic [7:0] step_limit,
    input wire logic step_busy
);
    // One domain, so clock and disable are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // Read address accepted
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Both write halves accepted at one edge
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Command in flight: field set, capture, go, engine done, result stored
    sequence s_cmd_run;
        step_busy [*5];
    endsequence

    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped early");
    a_read_answer: assert property (s_ar_taken |-> ##[1:2] s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_cmd_clears: assert property ($rose(step_busy) |-> s_cmd_run ##1 !step_busy)
        else $error("command field not cleared in time");
    a_apply_pulse: assert property (step_apply |=> !step_apply)
        else $error("apply pulse longer than one cycle");
    a_pulse_busy: assert property (step_apply || step_clear |-> step_busy)
        else $error("step pulse outside a command");
    a_pulse_excl: assert property (!(step_apply && step_clear))
        else $error("apply and clear together");
    a_capture_idle: assert property (!step_busy |=> $stable(step_targets)
        && $stable(step_limit) && $stable(step_amount)) else $error("capture while idle");
endmodule

bind psar_regs psar_regs_monitor psar_regs_monitor_i (.clk(clk), .srst(srst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .step_apply(step_apply), .step_clear(step_clear),
    .step_amount(step_amount), .step_targets(step_targets), .step_limit(step_limit),
    .step_busy(step_busy));
`default_nettype wire

// ===== tb/psar_regs_tb.sv
// Self-checking bench for the phase-step register bank.
// Assumes psar_regs is the top and speaks AXI4-Lite at byte addresses.
`timescale 1ns/1ps
`default_nettype none
`include "psar_consts.vh"
module psar_regs_tb;
    // Byte addresses are four times the register index
    localparam logic [15:0] A_CTRL = {2'b00, `PSAR_IDX_CTRL, 2'b00};
    localparam logic [15:0] A_STEP = {2'b00, `PSAR_IDX_STEP, 2'b00};
    localparam logic [15:0] A_LIM = {2'b00, `PSAR_IDX_LIMIT, 2'b00};
    localparam logic [15:0] A_MLO = {2'b00, `PSAR_IDX_MASK_LO, 2'b00};
    localparam logic [15:0] A_MHI = {2'b00, `PSAR_IDX_MASK_HI, 2'b00};
    logic clk, srst;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic step_apply, step_clear, step_busy;
    logic [31:0] step_amount;
    logic [`PSAR_NUM_DIV-1:0] step_targets;
    logic [7:0] step_limit;
    int mismatches, checks, apply_cnt, clear_cnt;
    logic [1:0] resp;
    logic [31:0] data;
    // Mask table: low byte, high byte, target vector, readback
    logic [59:0] tbl [8] = '{{8'h01, 8'h00, 12'h001, 32'h3}, {8'h02, 8'h00, 12'h002, 32'h0},
        {8'h10, 8'h00, 12'h004, 32'h0}, {8'h80, 8'h00, 12'h020, 32'h0},
        {8'h00, 8'h01, 12'h040, 32'h0}, {8'h00, 8'h08, 12'h200, 32'h0},
        {8'h00, 8'h10, 12'h400, 32'h0}, {8'h00, 8'h20, 12'h800, 32'h0}};

    psar_regs psar_regs_i (.clk(clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .step_apply(step_apply), .step_clear(step_clear),
        .step_amount(step_amount), .step_targets(step_targets), .step_limit(step_limit),
        .step_busy(step_busy));

    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Count step pulses seen by the phase mover
    always @(posedge clk)
    begin
        if (step_apply === 1'b1) apply_cnt++;
        if (step_clear === 1'b1) clear_cnt++;
    end

    // Compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Write: both halves offered together, bready held until bvalid
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            resp = s_axi_bresp;
        end
        while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        if (n >= 50) mismatches++;
    endtask

    // Read: rready held until rvalid, data taken at that edge
    task automatic rd(input logic [15:0] a);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            data = s_axi_rdata;
            resp = s_axi_rresp;
        end
        while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        if (n >= 50) mismatches++;
    endtask

    // Read and compare data plus an OKAY answer
    task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
        rd(a);
        chk(data, exp);
        chk({30'h0, resp}, {30'h0, `PSAR_RESP_OKAY});
    endtask

    // Issue a command, then poll until the field reads idle again
    task automatic cmd(input logic [1:0] code);
        int n;
        wr(A_CTRL, {30'h0, code});
        n = 0;
        do
        begin
            rd(A_CTRL);
            n++;
        end
        while (data[1:0] !== `PSAR_CMD_IDLE && n < 20);
        chk({30'h0, data[1:0]}, {30'h0, `PSAR_CMD_IDLE});
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog, well beyond the few hundred cycles the tests need
    initial
    begin
        #200000;
        mismatches++;
        summarize();
    end

    // Main sequence
    initial
    begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        {mismatches, checks, apply_cnt, clear_cnt} = '0;
        srst = 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rchk(A_STEP, `PSAR_STEP_RST);
        rchk(A_LIM, 32'h0);
        rchk(A_MLO, 32'h0);
        rchk(A_MHI, 32'h0);
        $display("reset values done");
        // Reserved mask bits stay zero
        wr(A_MLO, 32'hFF);
        rchk(A_MLO, 32'hF3);
        wr(A_MHI, 32'hFF);
        rchk(A_MHI, 32'h3F);
        wr(A_LIM, 32'h131);
        rchk(A_LIM, 32'h31);
        wr(A_STEP, 32'h8000_0001);
        rchk(A_STEP, 32'h8000_0001);
        $display("register access done");
        // Two write steps on one divider accumulate: 5 then -2
        wr(A_MLO, 32'h01);
        wr(A_MHI, 32'h00);
        wr(A_STEP, 32'h5);
        cmd(`PSAR_CMD_WRITE);
        wr(A_STEP, 32'hFFFF_FFFE);
        cmd(`PSAR_CMD_WRITE);
        chk(step_amount, 32'hFFFF_FFFE);
        chk({24'h0, step_limit}, 32'h31);
        chk(apply_cnt, 2);
        $display("accumulate done");
        // Eight of the mask bits map to their dividers; only the stepped one moved
        foreach (tbl[i])
        begin
            wr(A_MLO, {24'h0, tbl[i][59:52]});
            wr(A_MHI, {24'h0, tbl[i][51:44]});
            cmd(`PSAR_CMD_READ);
            chk({20'h0, step_targets}, {20'h0, tbl[i][43:32]});
            rchk(A_STEP, tbl[i][31:0]);
        end
        $display("mask map done");
        // Reset command zeroes the accumulator
        wr(A_MLO, 32'h01);
        wr(A_MHI, 32'h00);
        cmd(`PSAR_CMD_RESET);
        cmd(`PSAR_CMD_READ);
        rchk(A_STEP, 32'h0);
        chk(clear_cnt, 1);
        chk(apply_cnt, 2);
        $display("reset command done");
        // Unmapped place answers with a decode error and zero data
        rd(16'h0100);
        chk({30'h0, resp}, {30'h0, `PSAR_RESP_DECERR});
        chk(data, 32'h0);
        wr(16'h0100, 32'h1);
        chk({30'h0, resp}, {30'h0, `PSAR_RESP_DECERR});
        $display("unmapped done");
        summarize();
    end
endmodule
`default_nettype wire
